/* File: rtl/lsc_regs.vh */
// register offsets, field positions and reset values of the analog config bank
// included by every design file of the bank; definitions only
`ifndef LSC_REGS_VH
`define LSC_REGS_VH

// ==========================================================
// register offsets on the serial control port
`define LSC_OFS_RX_SETTINGS   8'h10
`define LSC_OFS_TERM_AB       8'h11
`define LSC_OFS_TERM_CD       8'h12
`define LSC_OFS_EQ_AB         8'h13
`define LSC_OFS_EQ_CD         8'h14
`define LSC_OFS_TX_SETTINGS   8'h20

// ==========================================================
// reset values and the read value of unmapped offsets
`define LSC_RST_RX_SETTINGS   8'h01
`define LSC_RST_TERM          8'h00
`define LSC_RST_EQ            8'h00
`define LSC_RST_TX_SETTINGS   8'h03
`define LSC_RD_UNMAPPED       8'h00
`define LSC_RST_MASTER_EN     1'b1
`define LSC_RST_PREEMPH       2'h0
`define LSC_RST_OUT_TERM      1'b1
`define LSC_RST_OUT_CUR       1'b1

// ==========================================================
// field positions
`define LSC_BIT_MASTER_EN     0
`define LSC_BIT_OUT_CUR       0
`define LSC_BIT_OUT_TERM      1
`define LSC_FLD_PREEMPH_LO    2
`define LSC_FLD_PREEMPH_HI    3
`define LSC_RX_SETTINGS_MASK  8'h01
`define LSC_TX_SETTINGS_MASK  8'h0F

// ==========================================================
// serial port framing
`define LSC_BYTE_BITS         4'h8
`define LSC_SLAVE_ADDR        7'h48

`endif

/* File: rtl/lsc_lane_map.v */
// per-lane mapping of termination and equalization bits onto source lanes
// assumes register values and master enable from the register bank, same clock
`timescale 1ns/1ps
`default_nettype none
`include "lsc_regs.vh"

module lsc_lane_map (
	// clock and reset
	input  wire       clk,
	input  wire       rst_n,
	// register contents
	input  wire [7:0] term_ab,
	input  wire [7:0] term_cd,
	input  wire [7:0] eq_ab,
	input  wire [7:0] eq_cd,
	input  wire       master_en,
	// per-source lane controls, index = lane number
	output reg  [3:0] term_a,
	output reg  [3:0] term_b,
	output reg  [3:0] term_c,
	output reg  [3:0] term_d,
	output reg  [3:0] eq_a,
	output reg  [3:0] eq_b,
	output reg  [3:0] eq_c,
	output reg  [3:0] eq_d
);

	// ==========================================================
	// one flop per lane control
	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_lane
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					term_a[i] <= 1'b0;
					term_b[i] <= 1'b0;
					term_c[i] <= 1'b0;
					term_d[i] <= 1'b0;
					eq_a[i]   <= 1'b0;
					eq_b[i]   <= 1'b0;
					eq_c[i]   <= 1'b0;
					eq_d[i]   <= 1'b0;
				end else begin
					// open unless master enable set; 1 connects the lane
					term_b[i] <= master_en & term_ab[i];
					term_a[i] <= master_en & term_ab[4 + i];
					term_c[i] <= master_en & term_cd[3 - i];
					term_d[i] <= master_en & term_cd[7 - i];
					// 1 selects high equalization
					eq_b[i]   <= eq_ab[i];
					eq_a[i]   <= eq_ab[4 + i];
					eq_c[i]   <= eq_cd[3 - i];
					eq_d[i]   <= eq_cd[7 - i];
				end
			end
		end
	endgenerate

endmodule
`default_nettype wire

/* File: rtl/lsc_config_regs.v */
// analog configuration register bank behind a two-wire serial slave port
// assumes scl/sda inputs synchronous to clk and sampled slower than clk
`timescale 1ns/1ps
`default_nettype none
`include "lsc_regs.vh"

module lsc_config_regs #(
	parameter [6:0] SLAVE_ADDR = `LSC_SLAVE_ADDR  // arbitrary default
) (
	// clock and reset
	input  wire       clk,
	input  wire       rst_n,
	// serial control port
	input  wire       scl,
	input  wire       sda_in,
	output reg        sda_out,
	output reg        sda_oe,
	// input lane controls
	output wire [3:0] lane_input_term_connect_a,
	output wire [3:0] lane_input_term_connect_b,
	output wire [3:0] lane_input_term_connect_c,
	output wire [3:0] lane_input_term_connect_d,
	output wire [3:0] lane_input_eq_high_a,
	output wire [3:0] lane_input_eq_high_b,
	output wire [3:0] lane_input_eq_high_c,
	output wire [3:0] lane_input_eq_high_d,
	// output stage controls and input termination master enable
	output reg  [1:0] output_preemph_level,
	output reg        output_term_on,
	output reg        output_current_high,
	output reg        input_term_master_enable
);

	// ==========================================================
	// states
	localparam [3:0] ST_IDLE  = 4'h0;
	localparam [3:0] ST_ADDR  = 4'h1;
	localparam [3:0] ST_AACK  = 4'h2;
	localparam [3:0] ST_PTR   = 4'h3;
	localparam [3:0] ST_WACK  = 4'h4;
	localparam [3:0] ST_WDATA = 4'h5;
	localparam [3:0] ST_RDATA = 4'h6;
	localparam [3:0] ST_MACK  = 4'h7;

	// ==========================================================
	// registers
	reg  [7:0] input_term_select_ab;
	reg  [7:0] input_term_select_cd;
	reg  [7:0] input_eq_select_ab;
	reg  [7:0] input_eq_select_cd;
	reg  [3:0] state;
	reg  [3:0] bit_cnt;
	reg  [7:0] shift;
	reg  [7:0] tx;
	reg  [7:0] ptr;
	reg        rw;
	reg        ack_ok;
	reg        scl_q;
	reg        sda_q;
	reg  [7:0] rd_byte;
	wire       scl_rise;
	wire       scl_fall;
	wire       bus_start;
	wire       bus_stop;
	wire [7:0] shift_in;
	wire [7:0] ptr_inc;

	assign scl_rise  = scl & ~scl_q;
	assign scl_fall  = ~scl & scl_q;
	assign bus_start = scl & scl_q & sda_q & ~sda_in;
	assign bus_stop  = scl & scl_q & ~sda_q & sda_in;
	assign shift_in  = {shift[6:0], sda_in};
	assign ptr_inc   = ptr + 8'h01;

	// ==========================================================
	// read mux, registers return stored value
	always @* begin
		case (ptr)
			`LSC_OFS_RX_SETTINGS: rd_byte = {7'h00, input_term_master_enable};
			`LSC_OFS_TERM_AB:     rd_byte = input_term_select_ab;
			`LSC_OFS_TERM_CD:     rd_byte = input_term_select_cd;
			`LSC_OFS_EQ_AB:       rd_byte = input_eq_select_ab;
			`LSC_OFS_EQ_CD:       rd_byte = input_eq_select_cd;
			`LSC_OFS_TX_SETTINGS: rd_byte = {4'h0, output_preemph_level,
				output_term_on, output_current_high};
			default:              rd_byte = `LSC_RD_UNMAPPED;
		endcase
	end

	// ==========================================================
	// serial slave and register writes
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_q                    <= 1'b1;
			sda_q                    <= 1'b1;
			sda_out                  <= 1'b0;
			sda_oe                   <= 1'b0;
			state                    <= ST_IDLE;
			bit_cnt                  <= 4'h0;
			shift                    <= 8'h00;
			tx                       <= 8'h00;
			ptr                      <= 8'h00;
			rw                       <= 1'b0;
			ack_ok                   <= 1'b0;
			input_term_master_enable <= `LSC_RST_MASTER_EN;
			input_term_select_ab     <= `LSC_RST_TERM;
			input_term_select_cd     <= `LSC_RST_TERM;
			input_eq_select_ab       <= `LSC_RST_EQ;
			input_eq_select_cd       <= `LSC_RST_EQ;
			output_preemph_level     <= `LSC_RST_PREEMPH;
			output_term_on           <= `LSC_RST_OUT_TERM;
			output_current_high      <= `LSC_RST_OUT_CUR;
		end else begin
			scl_q   <= scl;
			sda_q   <= sda_in;
			sda_out <= 1'b0;
			if (bus_start) begin
				state   <= ST_ADDR;
				bit_cnt <= 4'h0;
				sda_oe  <= 1'b0;
			end else if (bus_stop) begin
				state  <= ST_IDLE;
				sda_oe <= 1'b0;
			end else begin
				case (state)
					ST_IDLE: begin
						sda_oe <= 1'b0;
					end
					ST_ADDR, ST_PTR, ST_WDATA: begin
						if (scl_rise) begin
							shift   <= shift_in;
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall && bit_cnt == `LSC_BYTE_BITS) begin
							if (state == ST_ADDR) begin
								if (shift[7:1] == SLAVE_ADDR) begin
									rw     <= shift[0];
									sda_oe <= 1'b1;
									state  <= ST_AACK;
								end else begin
									state <= ST_IDLE;
								end
							end else begin
								sda_oe <= 1'b1;
								state  <= ST_WACK;
								if (state == ST_PTR) begin
									ptr <= shift;
								end else begin
									ptr <= ptr_inc;
									case (ptr)
										`LSC_OFS_RX_SETTINGS:
											input_term_master_enable <=
												shift[`LSC_BIT_MASTER_EN];
										`LSC_OFS_TERM_AB: input_term_select_ab <= shift;
										`LSC_OFS_TERM_CD: input_term_select_cd <= shift;
										`LSC_OFS_EQ_AB:   input_eq_select_ab   <= shift;
										`LSC_OFS_EQ_CD:   input_eq_select_cd   <= shift;
										`LSC_OFS_TX_SETTINGS: begin
											output_preemph_level <=
												shift[`LSC_FLD_PREEMPH_HI:`LSC_FLD_PREEMPH_LO];
											output_term_on       <= shift[`LSC_BIT_OUT_TERM];
											output_current_high  <= shift[`LSC_BIT_OUT_CUR];
										end
										default: begin
										end
									endcase
								end
							end
						end
					end
					ST_AACK: begin
						if (scl_fall) begin
							bit_cnt <= 4'h0;
							if (rw) begin
								tx     <= rd_byte;
								sda_oe <= ~rd_byte[7];
								state  <= ST_RDATA;
							end else begin
								sda_oe <= 1'b0;
								state  <= ST_PTR;
							end
						end
					end
					ST_WACK: begin
						if (scl_fall) begin
							sda_oe  <= 1'b0;
							bit_cnt <= 4'h0;
							state   <= ST_WDATA;
						end
					end
					ST_RDATA: begin
						if (scl_rise) begin
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall) begin
							if (bit_cnt == `LSC_BYTE_BITS) begin
								sda_oe <= 1'b0;
								ptr    <= ptr_inc;
								state  <= ST_MACK;
							end else begin
								tx     <= {tx[6:0], 1'b0};
								sda_oe <= ~tx[6];
							end
						end
					end
					ST_MACK: begin
						if (scl_rise) begin
							ack_ok <= ~sda_in;
						end else if (scl_fall) begin
							bit_cnt <= 4'h0;
							if (ack_ok) begin
								tx     <= rd_byte;
								sda_oe <= ~rd_byte[7];
								state  <= ST_RDATA;
							end else begin
								state <= ST_IDLE;
							end
						end
					end
					default: begin
						state  <= ST_IDLE;
						sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// lane mapping
	lsc_lane_map u_lane_map (
		.clk       (clk),
		.rst_n     (rst_n),
		.term_ab   (input_term_select_ab),
		.term_cd   (input_term_select_cd),
		.eq_ab     (input_eq_select_ab),
		.eq_cd     (input_eq_select_cd),
		.master_en (input_term_master_enable),
		.term_a    (lane_input_term_connect_a),
		.term_b    (lane_input_term_connect_b),
		.term_c    (lane_input_term_connect_c),
		.term_d    (lane_input_term_connect_d),
		.eq_a      (lane_input_eq_high_a),
		.eq_b      (lane_input_eq_high_b),
		.eq_c      (lane_input_eq_high_c),
		.eq_d      (lane_input_eq_high_d)
	);

endmodule
`default_nettype wire

/* File: testbench/lsc_checker.sv */
// concurrent checks on the ports of the analog config bank
// bound into lsc_config_regs; one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module lsc_checker (
	// clock and reset
	input wire       clk,
	input wire       rst_n,
	// serial port
	input wire       scl,
	input wire       sda_out,
	input wire       sda_oe,
	// lane and output controls
	input wire [3:0] lane_input_term_connect_a,
	input wire [3:0] lane_input_term_connect_b,
	input wire [3:0] lane_input_term_connect_c,
	input wire [3:0] lane_input_term_connect_d,
	input wire [3:0] lane_input_eq_high_a,
	input wire [3:0] lane_input_eq_high_b,
	input wire [3:0] lane_input_eq_high_c,
	input wire [3:0] lane_input_eq_high_d,
	input wire [1:0] output_preemph_level,
	input wire       output_term_on,
	input wire       output_current_high,
	input wire       input_term_master_enable
);
	wire [15:0] term = {lane_input_term_connect_a, lane_input_term_connect_b,
		lane_input_term_connect_c, lane_input_term_connect_d};
	wire [15:0] eq = {lane_input_eq_high_a, lane_input_eq_high_b,
		lane_input_eq_high_c, lane_input_eq_high_d};
	wire [4:0] tx = {output_preemph_level, output_term_on, output_current_high,
		input_term_master_enable};
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_scl_low2;
		!scl && !$past(scl);
	endsequence
	sequence s_oe_hold;
		sda_oe [*3];
	endsequence
	// ==========================================================
	// checks
	AST_SDA_OUT_LOW: assert property (sda_out == 1'b0)
		else $error("sda data value not zero");
	AST_OE_RISE: assert property ($rose(sda_oe) |-> s_scl_low2 ##0 s_oe_hold)
		else $error("sda pull-down started badly");
	AST_OE_FALL: assert property ($fell(sda_oe) |-> s_scl_low2)
		else $error("sda released while scl high");
	AST_OE_STABLE: assert property (scl |-> $stable(sda_oe))
		else $error("sda moved while scl high");
	AST_TERM_GATED: assert property (!$past(input_term_master_enable) |-> term == 16'h0000)
		else $error("termination connected with master off");
	AST_EQ_UNGATED: assert property ($changed(input_term_master_enable) |=> $stable(eq))
		else $error("equalization followed master enable");
	AST_TX_AT_SCL_LOW: assert property ($changed(tx) |-> s_scl_low2)
		else $error("output setting changed outside a write");
	AST_LANE_AT_SCL_LOW: assert property ($changed({term, eq}) |-> !$past(scl) && !$past(scl, 2))
		else $error("lane control changed outside a write");
endmodule
bind lsc_config_regs lsc_checker chk_u (
	.clk, .rst_n, .scl, .sda_out, .sda_oe,
	.lane_input_term_connect_a, .lane_input_term_connect_b,
	.lane_input_term_connect_c, .lane_input_term_connect_d,
	.lane_input_eq_high_a, .lane_input_eq_high_b,
	.lane_input_eq_high_c, .lane_input_eq_high_d,
	.output_preemph_level, .output_term_on, .output_current_high,
	.input_term_master_enable
);
`default_nettype wire

/* File: testbench/lsc_host.sv */
// two-wire serial master model of the host controller
// assumes sda is pulled up outside and fed back on sda
`timescale 1ns/1ps
`default_nettype none
module lsc_host (
	// clock
	input  wire  clk,
	// bus lines
	output logic scl,
	output logic sda_low,
	input  wire  sda
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// every move lands just after a clock edge
	task tk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task start();
		tk(2);
		sda_low = 1'b0;
		tk(2);
		scl = 1'b1;
		tk(3);
		sda_low = 1'b1;
		tk(3);
		scl = 1'b0;
	endtask
	task stop();
		tk(2);
		sda_low = 1'b1;
		tk(2);
		scl = 1'b1;
		tk(3);
		sda_low = 1'b0;
		tk(3);
	endtask
	task bit_x(input logic b, output logic r);
		tk(2);
		sda_low = ~b;
		tk(2);
		scl = 1'b1;
		tk(3);
		r = sda;
		scl = 1'b0;
	endtask
	task byte_w(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], r);
		bit_x(1'b1, r);
		ack = ~r;
	endtask
	task byte_r(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 0; i < 8; i++) begin
			bit_x(1'b1, r);
			d = {d[6:0], r};
		end
		bit_x(last, r);
	endtask
endmodule
`default_nettype wire

/* File: testbench/lsc_config_regs_tb.sv */
// self-checking bench for the analog config register bank
// drives the serial port through lsc_host; sda pulled up here
`timescale 1ns/1ps
`default_nettype none
`include "lsc_regs.vh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
	$display("FAIL %s exp %h got %h", n, e, a); end end
module lsc_config_regs_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	int mismatches = 0;
	int comparisons = 0;
	wire scl, sda_low, sda_out, sda_oe;
	wire sda = !(sda_oe || sda_low);
	wire [3:0] lane_input_term_connect_a, lane_input_term_connect_b;
	wire [3:0] lane_input_term_connect_c, lane_input_term_connect_d;
	wire [3:0] lane_input_eq_high_a, lane_input_eq_high_b;
	wire [3:0] lane_input_eq_high_c, lane_input_eq_high_d;
	wire [1:0] output_preemph_level;
	wire output_term_on, output_current_high, input_term_master_enable;
	wire [15:0] trm = {lane_input_term_connect_a, lane_input_term_connect_b,
		lane_input_term_connect_c, lane_input_term_connect_d};
	wire [15:0] eqv = {lane_input_eq_high_a, lane_input_eq_high_b,
		lane_input_eq_high_c, lane_input_eq_high_d};
	wire [4:0] tx = {output_preemph_level, output_term_on, output_current_high,
		input_term_master_enable};
	logic [7:0] ofs [6] = '{`LSC_OFS_RX_SETTINGS, `LSC_OFS_TERM_AB, `LSC_OFS_TERM_CD,
		`LSC_OFS_EQ_AB, `LSC_OFS_EQ_CD, `LSC_OFS_TX_SETTINGS};
	logic [7:0] rstv [6] = '{`LSC_RST_RX_SETTINGS, `LSC_RST_TERM, `LSC_RST_TERM,
		`LSC_RST_EQ, `LSC_RST_EQ, `LSC_RST_TX_SETTINGS};
	always #5 clk = ~clk;
	lsc_host host_u (.clk, .scl, .sda_low, .sda);
	lsc_config_regs dut_u (.clk, .rst_n, .scl, .sda_in(sda), .sda_out, .sda_oe,
		.lane_input_term_connect_a, .lane_input_term_connect_b,
		.lane_input_term_connect_c, .lane_input_term_connect_d,
		.lane_input_eq_high_a, .lane_input_eq_high_b,
		.lane_input_eq_high_c, .lane_input_eq_high_d,
		.output_preemph_level, .output_term_on, .output_current_high,
		.input_term_master_enable);
	// ==========================================================
	// helpers
	function automatic [15:0] lmap(input [7:0] ab, input [7:0] cd);
		return {ab[7:4], ab[3:0], cd[0], cd[1], cd[2], cd[3], cd[4], cd[5], cd[6], cd[7]};
	endfunction
	task wr(input [7:0] p, input [7:0] d);
		logic a;
		host_u.start();
		host_u.byte_w({`LSC_SLAVE_ADDR, 1'b0}, a);
		host_u.byte_w(p, a);
		host_u.byte_w(d, a);
		host_u.stop();
		`CHK("write ack", 1'b1, a)
	endtask
	task rd(input [7:0] p, output [7:0] d);
		logic a;
		host_u.start();
		host_u.byte_w({`LSC_SLAVE_ADDR, 1'b0}, a);
		host_u.byte_w(p, a);
		host_u.start();
		host_u.byte_w({`LSC_SLAVE_ADDR, 1'b1}, a);
		host_u.byte_r(1'b1, d);
		host_u.stop();
	endtask
	task results;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ==========================================================
	// tests
	initial begin
		logic [7:0] d, v;
		logic a;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		`CHK("tx reset", 5'h07, tx)
		`CHK("lane reset", 32'h0, ({trm, eqv}))
		for (int k = 0; k < 6; k++) begin
			rd(ofs[k], d);
			`CHK("reset value", rstv[k], d)
		end
		for (int k = 0; k < 8; k++) begin
			v = 8'h01 << k;
			wr(`LSC_OFS_TERM_AB, v);
			wr(`LSC_OFS_TERM_CD, v);
			wr(`LSC_OFS_EQ_AB, ~v);
			wr(`LSC_OFS_EQ_CD, ~v);
			`CHK("term lanes", lmap(v, v), trm)
			`CHK("eq lanes", lmap(~v, ~v), eqv)
			rd(`LSC_OFS_EQ_CD, d);
			`CHK("eq readback", ~v, d)
		end
		wr(`LSC_OFS_RX_SETTINGS, 8'hFE);
		`CHK("term master off", 16'h0000, trm)
		`CHK("eq master off", lmap(~v, ~v), eqv)
		wr(`LSC_OFS_RX_SETTINGS, 8'hFF);
		rd(`LSC_OFS_RX_SETTINGS, d);
		`CHK("master readback", 8'h01, d)
		`CHK("term master on", lmap(v, v), trm)
		for (int k = 0; k < 4; k++) begin
			v = {4'hF, k[1:0], k[0], k[1]};
			wr(`LSC_OFS_TX_SETTINGS, v);
			`CHK("tx outputs", ({v[3:0], 1'b1}), tx)
			rd(`LSC_OFS_TX_SETTINGS, d);
			`CHK("tx readback", v & `LSC_TX_SETTINGS_MASK, d)
		end
		wr(8'h30, 8'h5A);
		rd(8'h30, d);
		`CHK("unmapped read", `LSC_RD_UNMAPPED, d)
		host_u.start();
		host_u.byte_w({`LSC_SLAVE_ADDR ^ 7'h01, 1'b0}, a);
		host_u.stop();
		`CHK("foreign address ack", 1'b0, a)
		// mid-run reset must bring every setting back to its reset value
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		`CHK("tx rerun reset", 5'h07, tx)
		`CHK("lane rerun reset", 32'h0, ({trm, eqv}))
		rd(`LSC_OFS_TX_SETTINGS, d);
		`CHK("tx rerun readback", `LSC_RST_TX_SETTINGS, d)
		results();
	end
	initial begin
		repeat (60000) @(posedge clk);
		mismatches++;
		results();
	end
endmodule
`default_nettype wire
